// file: core/sadc_pkg.sv
package sadc_pkg;
	// register byte offsets (word aligned)
	localparam logic [7:0] CTRL_OFS    = 8'h00;
	localparam logic [7:0] TIMING_OFS  = 8'h04;
	localparam logic [7:0] SELECT_OFS  = 8'h08;
	localparam logic [7:0] COMMAND_OFS = 8'h0C;
	localparam logic [7:0] INTCTRL_OFS = 8'h10;
	localparam logic [7:0] FLAGS_OFS   = 8'h14;
	localparam logic [7:0] RESULT_OFS  = 8'h18;
	localparam logic [7:0] STATUS_OFS  = 8'h1C;
	// control field positions
	localparam int CTRL_ENABLE_BIT   = 0;
	localparam int CTRL_FREE_RUNNING_ENABLE_BIT  = 1;
	localparam int CTRL_RESOLUTION_SELECT_BIT   = 2;
	localparam int CTRL_START_EVENT_INPUT_ENABLE_BIT  = 3;
	localparam int CTRL_DEBUG_RUN_ENABLE_BIT   = 4;
	localparam int CTRL_PRESCALER_SELECT_LSB    = 8;
	localparam int CTRL_ACCUM_LSB    = 12;
	localparam int TIMING_DLY_LSB    = 0;
	localparam int TIMING_LEN_LSB    = 8;
	localparam int SELECT_CHAN_LSB   = 0;
	localparam int SELECT_REF_LSB    = 8;
	// conversion timing in converter clocks (START_EXTRA in peripheral clocks)
	localparam int CONV_CYCLES       = 13;
	localparam int SAMPLE_BASE       = 2;
	localparam int START_EXTRA       = 2;
	localparam int RESULT_W          = 10;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

	// selections that are shadowed and locked together
	typedef struct packed {
		logic [4:0] input_channel_select;
		logic [2:0] reference_select;
	} sadc_sel_t;

	// wishbone request bundle
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} sadc_wb_req_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_CONV = 3'b100
	} sadc_state_t;
endpackage

// file: core/sadc_prescaler.sv
`timescale 1ns/10ps
// divides the peripheral clock; emits a one-cycle tick on each converter rising edge
module sadc_prescaler
	import sadc_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic       reset_n_i,
	input  wire logic       hold_i,
	input  wire logic [2:0] prescaler_select_i,
	output logic            tick_o
);
	logic [8:0] count;
	logic [8:0] next_count;
	logic       next_tick;
	logic [8:0] half;

	// factor is 2^(sel+1); rising edge falls at half the period
	always_comb begin
		half       = 9'(1) << prescaler_select_i;
		next_count = count + 9'd1;
		if (hold_i || next_count == (half << 1)) begin
			next_count = '0;
		end
		next_tick = !hold_i && (count + 9'd1 == half);
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			count  <= '0;
			tick_o <= 1'b0;
		end else begin
			count  <= next_count;
			tick_o <= next_tick;
		end
	end
endmodule

// file: core/sadc_sequencer.sv
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module sadc_sequencer
	import sadc_pkg::*;
(
	input  wire logic                 mclk_i,
	input  wire logic                 reset_n_i,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic [31:0]               wb_dat_o,
	output logic                      wb_ack_o,
	input  wire logic                 debug_halt_i,
	input  wire logic                 start_event_i,
	input  wire logic                 global_irq_enable_i,
	input  wire logic [RESULT_W-1:0]  analog_data_i,
	output logic                      irq_o,
	output logic                      sample_hold_o,
	output logic                      converting_o,
	output sadc_sel_t                 active_sel_o
);
	// control state
	logic        enable;
	logic        free_running_enable;
	logic        resolution_select;
	logic        start_event_input_enable;
	logic        debug_run_enable;
	logic [2:0]  prescaler_select;
	logic [2:0]  accumulation_count;
	logic [7:0]  sample_delay;
	logic [7:0]  sample_length;
	sadc_sel_t   shadow_sel;
	logic        irq_enable;
	logic        start_conversion;
	logic        result_ready;
	logic [15:0] conversion_result;
	logic [15:0] accum;
	logic [6:0]  accum_done;
	sadc_state_t state;
	logic [9:0]  cycle;
	logic [2:0]  evt_sync;

	logic        next_enable;
	logic        next_free_running_enable;
	logic        next_resolution_select;
	logic        next_start_event_input_enable;
	logic        next_debug_run_enable;
	logic [2:0]  next_prescaler_select;
	logic [2:0]  next_accumulation_count;
	logic [7:0]  next_sample_delay;
	logic [7:0]  next_sample_length;
	sadc_sel_t   next_shadow_sel;
	logic        next_irq_enable;
	logic        next_start_conversion;
	logic        next_result_ready;
	logic [15:0] next_conversion_result;
	logic [15:0] next_accum;
	logic [6:0]  next_accum_done;
	sadc_state_t next_state;
	logic [9:0]  next_cycle;
	sadc_sel_t   next_active_sel;
	logic        next_sample_hold;
	logic        next_irq;
	logic [31:0] next_rdata;
	logic        next_ack;

	logic        tick;
	logic        run;
	logic        wr;
	logic        rd;
	logic        evt_edge;
	logic [9:0]  conv_len;
	logic [9:0]  sample_at;
	logic [6:0]  accum_target;

	function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
		hit = adr == ofs;
	endfunction

	// prescaler only runs while a conversion is waiting or running
	sadc_prescaler u_prescaler_select (
		.mclk_i             (mclk_i),
		.reset_n_i          (reset_n_i),
		.hold_i             (!enable || state == ST_IDLE || !run),
		.prescaler_select_i (prescaler_select),
		.tick_o             (tick)
	);

	// debug halt freezes the sequence unless debug_run_enable is set, but not the bus
	assign run      = !debug_halt_i || debug_run_enable;
	assign wr       = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign rd       = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
	assign evt_edge = evt_sync[1] && !evt_sync[2];
	// delays stretch sampling and so the whole conversion
	assign conv_len  = 10'(CONV_CYCLES) + 10'(sample_delay) + 10'(sample_length);
	assign sample_at = 10'(SAMPLE_BASE) + 10'(sample_delay) + 10'(sample_length);
	assign accum_target = 7'(1) << accumulation_count;

	// event input crosses in from the event system
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			evt_sync <= '0;
		end else begin
			evt_sync <= {evt_sync[1:0], start_event_i};
		end
	end

	// register writes, sequencing and flags
	always_comb begin
		next_enable                   = enable;
		next_free_running_enable      = free_running_enable;
		next_resolution_select        = resolution_select;
		next_start_event_input_enable = start_event_input_enable;
		next_debug_run_enable         = debug_run_enable;
		next_prescaler_select         = prescaler_select;
		next_accumulation_count       = accumulation_count;
		next_sample_delay             = sample_delay;
		next_sample_length            = sample_length;
		next_shadow_sel               = shadow_sel;
		next_irq_enable               = irq_enable;
		next_start_conversion         = start_conversion;
		next_result_ready             = result_ready;
		next_conversion_result        = conversion_result;
		next_accum                    = accum;
		next_accum_done               = accum_done;
		next_state                    = state;
		next_cycle                    = cycle;
		next_active_sel               = active_sel_o;
		next_sample_hold              = 1'b0;

		if (wr && hit(wb_adr_i, CTRL_OFS) && wb_sel_i[0]) begin
			next_enable                   = wb_dat_i[CTRL_ENABLE_BIT];
			next_free_running_enable      = wb_dat_i[CTRL_FREE_RUNNING_ENABLE_BIT];
			next_resolution_select        = wb_dat_i[CTRL_RESOLUTION_SELECT_BIT];
			next_start_event_input_enable = wb_dat_i[CTRL_START_EVENT_INPUT_ENABLE_BIT];
			next_debug_run_enable         = wb_dat_i[CTRL_DEBUG_RUN_ENABLE_BIT];
		end
		if (wr && hit(wb_adr_i, CTRL_OFS) && wb_sel_i[1]) begin
			next_prescaler_select   = wb_dat_i[CTRL_PRESCALER_SELECT_LSB +: 3];
			next_accumulation_count = wb_dat_i[CTRL_ACCUM_LSB +: 3];
		end
		if (wr && hit(wb_adr_i, TIMING_OFS)) begin
			if (wb_sel_i[0]) begin
				next_sample_delay = wb_dat_i[TIMING_DLY_LSB +: 8];
			end
			if (wb_sel_i[1]) begin
				next_sample_length = wb_dat_i[TIMING_LEN_LSB +: 8];
			end
		end
		// software only ever reaches the shadow copy
		if (wr && hit(wb_adr_i, SELECT_OFS)) begin
			if (wb_sel_i[0]) begin
				next_shadow_sel.input_channel_select = wb_dat_i[SELECT_CHAN_LSB +: 5];
			end
			if (wb_sel_i[1]) begin
				next_shadow_sel.reference_select = wb_dat_i[SELECT_REF_LSB +: 3];
			end
		end
		if (wr && hit(wb_adr_i, INTCTRL_OFS) && wb_sel_i[0]) begin
			next_irq_enable = wb_dat_i[0];
		end
		// write-one or result read clears; completion below wins
		if ((wr && hit(wb_adr_i, FLAGS_OFS) && wb_sel_i[0] && wb_dat_i[0]) ||
			(rd && hit(wb_adr_i, RESULT_OFS))) begin
			next_result_ready = 1'b0;
		end

		// start by command one or event edge; zero written is ignored
		if (next_enable && state == ST_IDLE &&
			((wr && hit(wb_adr_i, COMMAND_OFS) && wb_sel_i[0] && wb_dat_i[0]) ||
			(start_event_input_enable && evt_edge))) begin
			next_start_conversion = 1'b1;
			next_state            = ST_WAIT;
			next_accum            = '0;
			next_accum_done       = '0;
		end

		// shadow follows into active while idle and enabled, and again at cycle conv_len - 1 of each conversion
		if (enable && state == ST_IDLE) begin
			next_active_sel = shadow_sel;
		end

		if (!enable) begin
			next_state            = ST_IDLE;
			next_start_conversion = 1'b0;
		end else if (run && tick) begin
			case (state)
				ST_WAIT: begin
					// first converter edge after the trigger starts it
					next_state = ST_CONV;
					next_cycle = 10'd1;
				end
				ST_CONV: begin
					next_cycle = cycle + 10'd1;
					if (cycle == sample_at) begin
						next_sample_hold = 1'b1;
					end
					if (cycle == conv_len - 10'd1) begin
						next_active_sel = shadow_sel;
					end
					if (cycle == conv_len) begin
						next_cycle      = 10'd1;
						next_accum      = accum + 16'(analog_data_i);
						next_accum_done = accum_done + 7'd1;
						if (accum_done + 7'd1 == accum_target) begin
							// whole accumulated sequence done
							next_result_ready      = 1'b1;
							next_conversion_result = accum + 16'(analog_data_i);
							next_accum             = '0;
							next_accum_done        = '0;
							if (!free_running_enable) begin
								next_start_conversion = 1'b0;
								next_state            = ST_IDLE;
							end
						end
						// free-running: next conversion starts at once
					end
				end
				default: begin
					next_state = ST_IDLE;
				end
			endcase
		end else if (state == ST_CONV) begin
			// locked while converting, no shadow transfer
			next_active_sel = active_sel_o;
		end

		next_irq = next_result_ready && next_irq_enable && global_irq_enable_i;
	end

	// bus read mux
	always_comb begin
		next_rdata = ZERO_WORD;
		next_ack   = wb_cyc_i && wb_stb_i && !wb_ack_o;
		case (wb_adr_i)
			CTRL_OFS: begin
				next_rdata = {17'd0, accumulation_count, 1'b0, prescaler_select, 3'd0,
					debug_run_enable, start_event_input_enable, resolution_select,
					free_running_enable, enable};
			end
			TIMING_OFS:  next_rdata = {16'd0, sample_length, sample_delay};
			SELECT_OFS:  next_rdata = {21'd0, shadow_sel.reference_select, 3'd0,
				shadow_sel.input_channel_select};
			COMMAND_OFS: next_rdata = {31'd0, start_conversion};
			INTCTRL_OFS: next_rdata = {31'd0, irq_enable};
			FLAGS_OFS:   next_rdata = {31'd0, result_ready};
			RESULT_OFS:  next_rdata = {16'd0, conversion_result};
			STATUS_OFS:  next_rdata = {24'd0, 5'(state), 3'(active_sel_o.reference_select)};
			default:     next_rdata = ZERO_WORD;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			enable                   <= CTRL_RESET[CTRL_ENABLE_BIT];
			free_running_enable      <= 1'b0;
			resolution_select        <= 1'b0;
			start_event_input_enable <= 1'b0;
			debug_run_enable         <= 1'b0;
			prescaler_select         <= '0;
			accumulation_count       <= '0;
			sample_delay             <= '0;
			sample_length            <= '0;
			shadow_sel               <= '0;
			irq_enable               <= 1'b0;
			start_conversion         <= 1'b0;
			result_ready             <= 1'b0;
			conversion_result        <= '0;
			accum                    <= '0;
			accum_done               <= '0;
			state                    <= ST_IDLE;
			cycle                    <= '0;
			active_sel_o             <= '0;
			sample_hold_o            <= 1'b0;
			converting_o             <= 1'b0;
			irq_o                    <= 1'b0;
			wb_dat_o                 <= '0;
			wb_ack_o                 <= 1'b0;
		end else begin
			enable                   <= next_enable;
			free_running_enable      <= next_free_running_enable;
			resolution_select        <= next_resolution_select;
			start_event_input_enable <= next_start_event_input_enable;
			debug_run_enable         <= next_debug_run_enable;
			prescaler_select         <= next_prescaler_select;
			accumulation_count       <= next_accumulation_count;
			sample_delay             <= next_sample_delay;
			sample_length            <= next_sample_length;
			shadow_sel               <= next_shadow_sel;
			irq_enable               <= next_irq_enable;
			start_conversion         <= next_start_conversion;
			result_ready             <= next_result_ready;
			conversion_result        <= next_conversion_result;
			accum                    <= next_accum;
			accum_done               <= next_accum_done;
			state                    <= next_state;
			cycle                    <= next_cycle;
			active_sel_o             <= next_active_sel;
			sample_hold_o            <= next_sample_hold;
			converting_o             <= next_state == ST_CONV;
			irq_o                    <= next_irq;
			wb_dat_o                 <= next_rdata;
			wb_ack_o                 <= next_ack;
		end
	end
endmodule

// file: dv/sadc_far_model.sv
`timescale 1ns/10ps
// far side: event source and converter core output
module sadc_far_model
	import sadc_pkg::*;
(
	input  wire logic                mclk_i,
	input  wire logic                fire_i,
	input  wire logic [RESULT_W-1:0] level_i,
	output logic                     event_o,
	output logic [RESULT_W-1:0]      analog_o
);
	logic [2:0] hold_cnt = 3'h0;
	// stretch the event so the synchroniser sees one clean rise
	always_ff @(posedge mclk_i) begin
		if (fire_i)
			hold_cnt <= 3'h4;
		else if (hold_cnt != 3'h0)
			hold_cnt <= hold_cnt - 3'h1;
	end
	assign event_o  = (hold_cnt != 3'h0);
	assign analog_o = level_i;  // level only changes while idle
endmodule

// file: dv/sadc_monitor.sv
`timescale 1ns/10ps
// port checker for the sequencer; mirrors control bits from bus writes
module sadc_monitor
	import sadc_pkg::*;
(
	input wire logic      mclk_i,
	input wire logic      reset_n_i,
	input wire logic      wb_cyc_i,
	input wire logic      wb_stb_i,
	input wire logic      wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic      wb_ack_o,
	input wire logic      debug_halt_i,
	input wire logic      global_irq_enable_i,
	input wire logic      irq_o,
	input wire logic      sample_hold_o,
	input wire logic      converting_o,
	input wire sadc_sel_t active_sel_o
);
	logic [7:0] ctrl, next_ctrl;
	// shadow lags the design by one edge: clearing a bit shrinks the antecedents, setting one widens them for an edge
	always_comb begin
		next_ctrl = ctrl;
		if (wb_ack_o && wb_we_i && wb_adr_i == CTRL_OFS && wb_sel_i[0])
			next_ctrl = wb_dat_i[7:0];
	end
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i)
			ctrl <= 8'h00;
		else
			ctrl <= next_ctrl;
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h1F |-> wb_dat_o == ZERO_WORD)
		else $error("unmapped read not zero");
	a_irq_global: assert property (irq_o |-> $past(global_irq_enable_i))
		else $error("irq without global enable");
	a_sh_in_conv: assert property (sample_hold_o |-> converting_o)
		else $error("sample pulse outside conversion");
	a_conv_min_len: assert property ($rose(converting_o) |-> converting_o[*8])
		else $error("conversion too short");
	a_sel_locked: assert property (sample_hold_o |-> active_sel_o == $past(active_sel_o, 2))
		else $error("selection moved before sampling");
	a_debug_freeze: assert property (debug_halt_i && $past(debug_halt_i) && !ctrl[4]
		|=> $stable(converting_o))
		else $error("sequencer ran while halted");
	a_disabled_idle: assert property (!ctrl[0] && !converting_o |=> !converting_o)
		else $error("conversion while disabled");
	c_conv: cover property ($rose(converting_o));
	c_irq: cover property ($rose(irq_o));
	c_halt_run: cover property (debug_halt_i && converting_o);
endmodule

bind sadc_sequencer sadc_monitor u_mon (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.debug_halt_i(debug_halt_i), .global_irq_enable_i(global_irq_enable_i), .irq_o(irq_o),
	.sample_hold_o(sample_hold_o), .converting_o(converting_o), .active_sel_o(active_sel_o));

// file: dv/tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
	import sadc_pkg::*;
	logic                mclk_i = 1'b0;
	logic                reset_n_i = 1'b0;
	logic                halt = 1'b0;
	logic                gie = 1'b0;
	logic                fire = 1'b0;
	logic                ack, irq, sh, conv, evt, conv_d;
	logic [31:0]         rdat, rd;
	logic [31:0]         rng = 32'h0001_7989;
	logic [RESULT_W-1:0] level = 10'h000;
	logic [RESULT_W-1:0] adata;
	sadc_wb_req_t        req = '0;
	sadc_sel_t           asel;
	int                  mismatches = 0;
	int                  num_checks = 0;
	int                  cyc_n = 0, t_ack, t_rise, t_fall, t_sh, t_sh_prev;

	always #10 mclk_i = ~mclk_i;

	sadc_sequencer dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .wb_cyc_i(req.cyc),
		.wb_stb_i(req.stb), .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr),
		.wb_dat_i(req.dat), .wb_dat_o(rdat), .wb_ack_o(ack), .debug_halt_i(halt),
		.start_event_i(evt), .global_irq_enable_i(gie), .analog_data_i(adata), .irq_o(irq),
		.sample_hold_o(sh), .converting_o(conv), .active_sel_o(asel));
	sadc_far_model u_far (.mclk_i(mclk_i), .fire_i(fire), .level_i(level), .event_o(evt),
		.analog_o(adata));

	// edge indices of conversion events for the timing checks
	always @(posedge mclk_i) begin
		cyc_n <= cyc_n + 1;
		conv_d <= conv;
		if (conv && !conv_d)
			t_rise <= cyc_n;
		if (!conv && conv_d)
			t_fall <= cyc_n;
		if (sh) begin
			t_sh <= cyc_n;
			t_sh_prev <= t_sh;
		end
	end

	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	// classic single cycle; data taken at the ack edge
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int t;
		t = 0;
		req <= '{1'b1, 1'b1, we, 4'hF, adr, dat};
		do begin
			@(posedge mclk_i);
			t++;
		end while (ack !== 1'b1 && t < 50);
		// a bus that never answers counts against the run
		if (ack !== 1'b1) begin
			mismatches++;
		end
		t_ack = cyc_n;
		rd = rdat;
		req <= '0;
		@(posedge mclk_i);
	endtask

	// software polls the flag without any interrupt
	task automatic poll();
		int t;
		t = 0;
		do begin
			wb(1'b0, FLAGS_OFS, 32'h0000_0000);
			t++;
		end while (rd[0] !== 1'b1 && t < 400);
		`CHK(rd[0], 1'b1)
	endtask

	task automatic trial(input int p, input int d, input int l, input int a);
		int f;
		int t0;
		f = 2 << p;
		level <= 10'(xs());
		wb(1'b1, TIMING_OFS, 32'(d + (l << 8)));
		wb(1'b1, CTRL_OFS, 32'(1 + (p << 8) + (a << 12)));
		wb(1'b1, COMMAND_OFS, 32'h0000_0001);
		t0 = t_ack;
		wb(1'b1, COMMAND_OFS, 32'h0000_0001);
		wb(1'b0, COMMAND_OFS, 32'h0000_0000);
		`CHK(rd[0], 1'b1)
		poll();
		if (a == 0) begin
			`CHK(t_rise - t0 + 1, f / 2 + START_EXTRA)
			`CHK(t_fall - t_rise, (CONV_CYCLES + d + l) * f)
			`CHK(t_sh - t_rise, (SAMPLE_BASE + d + l) * f)
		end
		wb(1'b0, COMMAND_OFS, 32'h0000_0000);
		`CHK(rd[0], 1'b0)
		`CHK(irq, 1'b0)
		wb(1'b0, RESULT_OFS, 32'h0000_0000);
		`CHK(rd, 32'(level) << a)
		wb(1'b0, FLAGS_OFS, 32'h0000_0000);
		`CHK(rd[0], 1'b0)
	endtask

	task automatic wrap_up();
		if (mismatches == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		int p;
		repeat (8) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		gie <= 1'b1;
		wb(1'b0, CTRL_OFS, 32'h0000_0000);
		`CHK(rd, CTRL_RESET)
		wb(1'b0, STATUS_OFS, 32'h0000_0000);
		`CHK(rd, 32'(ST_IDLE) << 3)
		wb(1'b1, 8'h40, 32'hFFFF_FFFF);
		wb(1'b0, 8'h40, 32'h0000_0000);
		`CHK(rd, ZERO_WORD)
		// while disabled the selection stays in the shadow copy and start is ignored
		wb(1'b1, SELECT_OFS, 32'h0000_0305);
		wb(1'b1, COMMAND_OFS, 32'h0000_0001);
		repeat (20) @(posedge mclk_i);
		`CHK(asel, 8'h00)
		`CHK(conv, 1'b0)
		wb(1'b1, CTRL_OFS, 32'h0000_0001);
		wb(1'b1, COMMAND_OFS, 32'h0000_0000);
		repeat (20) @(posedge mclk_i);
		`CHK(asel, sadc_sel_t'{5'h05, 3'h3})
		`CHK(conv, 1'b0)
		trial(0, 0, 0, 0);
		trial(2, 3, 3, 0);
		repeat (3) trial(xs() % 3, xs() % 4, xs() % 4, 0);
		trial(1, 1, 0, 1);
		trial(0, 0, 1, 2);
		// selection written mid-conversion waits for the end
		wb(1'b1, COMMAND_OFS, 32'h0000_0001);
		repeat (8) @(posedge mclk_i);
		wb(1'b1, SELECT_OFS, 32'h0000_0112);
		`CHK(asel, sadc_sel_t'{5'h05, 3'h3})
		poll();
		`CHK(asel, sadc_sel_t'{5'h12, 3'h1})
		// clear the stale flag so the free-running polls see fresh completions
		wb(1'b1, FLAGS_OFS, 32'h0000_0001);
		// free-running: spacing of consecutive sample pulses
		p = xs() % 3;
		wb(1'b1, CTRL_OFS, 32'(3 + (p << 8)));
		wb(1'b1, COMMAND_OFS, 32'h0000_0001);
		poll();
		wb(1'b1, FLAGS_OFS, 32'h0000_0001);
		poll();
		// timing still holds delay 0 and length 1 from the last trial
		`CHK(t_sh - t_sh_prev, (CONV_CYCLES + 0 + 1) * (2 << p))
		wb(1'b1, CTRL_OFS, 32'h0000_0000);
		repeat (200) @(posedge mclk_i);
		`CHK(conv, 1'b0)
		wb(1'b1, FLAGS_OFS, 32'h0000_0001);
		// interrupt gating and write-one clear
		wb(1'b1, CTRL_OFS, 32'h0000_0001);
		wb(1'b1, INTCTRL_OFS, 32'h0000_0001);
		wb(1'b1, COMMAND_OFS, 32'h0000_0001);
		poll();
		`CHK(irq, 1'b1)
		gie <= 1'b0;
		repeat (2) @(posedge mclk_i);
		`CHK(irq, 1'b0)
		wb(1'b1, FLAGS_OFS, 32'h0000_0001);
		gie <= 1'b1;
		wb(1'b0, FLAGS_OFS, 32'h0000_0000);
		`CHK(rd[0], 1'b0)
		// event start
		wb(1'b1, CTRL_OFS, 32'h0000_0009);
		fire <= 1'b1;
		@(posedge mclk_i);
		fire <= 1'b0;
		repeat (8) @(posedge mclk_i);
		wb(1'b0, COMMAND_OFS, 32'h0000_0000);
		`CHK(rd[0], 1'b1)
		poll();
		wb(1'b0, COMMAND_OFS, 32'h0000_0000);
		`CHK(rd[0], 1'b0)
		wb(1'b1, FLAGS_OFS, 32'h0000_0001);
		// debug halt freezes unless debug-run is set
		halt <= 1'b1;
		wb(1'b1, CTRL_OFS, 32'h0000_0001);
		wb(1'b1, COMMAND_OFS, 32'h0000_0001);
		repeat (100) @(posedge mclk_i);
		`CHK(conv, 1'b0)
		halt <= 1'b0;
		poll();
		wb(1'b1, FLAGS_OFS, 32'h0000_0001);
		wb(1'b1, CTRL_OFS, 32'h0000_0011);
		halt <= 1'b1;
		wb(1'b1, COMMAND_OFS, 32'h0000_0001);
		poll();
		halt <= 1'b0;
		wrap_up();
	end

	// hang guard, well beyond the expected run length
	initial begin
		#(20 * 40000);
		mismatches++;
		wrap_up();
	end
endmodule
